// [rtl/e1_oh_pkg.sv]
// Purpose: shared constants, types and helpers for the E1 overhead bit monitor
// Assumes: 50 MHz core clock; registers reached over APB
// Notes: register byte address is the register index times four
package e1_oh_pkg;

    localparam int CLK_HZ        = 50_000_000;
    localparam int RAI_TIME_MS   = 10;
    localparam int RAI_CYCLES    = (CLK_HZ / 1000) * RAI_TIME_MS;
    localparam int SECOND_S      = 1;
    localparam int SECOND_CYCLES = CLK_HZ * SECOND_S;
    localparam int FAR_END_BLOCK_ERROR_SECONDS  = 5;
    localparam logic [9:0] FAR_END_BLOCK_ERROR_PER_SECOND = 10'h3DE;

    localparam logic [4:0][11:0] SPECIAL_CODES =
        {12'hFFF, 12'hEEE, 12'hCCC, 12'hAAA, 12'h888};
    localparam logic [3:0] NT_CRC_CODE_A  = 4'h2;
    localparam logic [3:0] NT_BOTH_CODE   = 4'h3;
    localparam logic [3:0] NT_FAR_END_BLOCK_ERROR_CODE_A = 4'h1;

    localparam logic [7:0] IDX_SA_CTRL = 8'h5C;
    localparam logic [7:0] IDX_SA_IND  = 8'h5D;
    localparam logic [7:0] IDX_OH_STAT = 8'h5F;
    localparam logic [7:0] IDX_OH_CTRL = 8'h60;
    localparam logic [7:0] IDX_OH_IND  = 8'h61;
    localparam logic [7:0] REG_RESET   = 8'h00;

    localparam int SA_MODE_BIT   = 7;
    localparam int SA_DEB_BIT    = 6;
    localparam int SA_SPEC_BIT   = 5;
    localparam int NAT_BITS      = 5;
    localparam int SA6_POS       = 2;
    localparam int SA7_POS       = 1;
    localparam int OH_BITS       = 6;
    localparam int OH_NT_CRC     = 5;
    localparam int OH_NT_FAR_END_BLOCK_ERROR    = 4;
    localparam int OH_FAR_END_BLOCK_ERROR       = 3;
    localparam int OH_RAI_CHG    = 2;
    localparam int OH_CFEBE_CHG  = 1;
    localparam int OH_LINK_CHG   = 0;

    typedef enum logic [2:0] {
        SEL_NONE    = 3'b000,
        SEL_SA_CTRL = 3'b001,
        SEL_SA_IND  = 3'b010,
        SEL_OH_STAT = 3'b011,
        SEL_OH_CTRL = 3'b100,
        SEL_OH_IND  = 3'b101
    } regsel_e;

    // Framer timing; saBits[4] is Sa4 down to saBits[0] is Sa8
    typedef struct packed {
        logic       basicSync;
        logic       crcMfSync;
        logic       nfasStrobe;
        logic       aBit;
        logic [4:0] saBits;
        logic       eStrobe;
        logic       eBit;
        logic       smfEnd;
    } frame_s;

    function automatic logic isSpecial(input logic [11:0] w);
        isSpecial = 1'b0;
        for (int i = 0; i < 5; i++) begin
            if (w == SPECIAL_CODES[i]) begin
                isSpecial = 1'b1;
            end
        end
    endfunction

endpackage

// [rtl/nat_word_capture.sv]
// Purpose: collect one national bit into 4-bit codewords per sub multiframe
// Assumes: bitStrobe pulses once per NFAS frame, smfEnd after the fourth
// Notes: word holds while CRC multiframe sync is lost
`timescale 1ns/1ns
`default_nettype none
module nat_word_capture (
    input  wire logic       core_clk,
    input  wire logic       rstn,
    input  wire logic       crcMfSync,
    input  wire logic       bitStrobe,
    input  wire logic       bitIn,
    input  wire logic       smfEnd,
    input  wire logic       debounceEn,
    output logic [3:0]      rawWord,
    output logic [3:0]      word,
    output logic            changed
);
    typedef struct packed {
        logic [3:0] shift;
        logic [3:0] last;
        logic [3:0] word;
        logic       changed;
    } cap_s;

    cap_s q;
    cap_s d;

    always_comb begin
        d = q;
        d.changed = 1'b0;
        if (bitStrobe) begin
            d.shift = {q.shift[2:0], bitIn};
        end
        if (smfEnd && crcMfSync) begin
            d.last = q.shift;
            if (!debounceEn || q.shift == q.last) begin
                d.word = q.shift;
                d.changed = (q.shift != q.word);
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign rawWord = q.shift;
    assign word    = q.word;
    assign changed = q.changed;

    debounce_hold_a: assert property (@(posedge core_clk) disable iff (!rstn)
        smfEnd && debounceEn && q.shift != q.last |=> $stable(q.word))
        else $error("Codeword updated without a repeat while debounce is on");

endmodule // nat_word_capture
`default_nettype wire

// [rtl/zero_second_monitor.sv]
// Purpose: flag a run of seconds each holding enough zero E bits
// Assumes: zeroEvt pulses once per received zero E bit
// Notes: all history clears while disabled
`timescale 1ns/1ns
`default_nettype none
module zero_second_monitor #(
    parameter int SECOND_CYCLES_P = e1_oh_pkg::SECOND_CYCLES
) (
    input  wire logic core_clk,
    input  wire logic rstn,
    input  wire logic enable,
    input  wire logic zeroEvt,
    output logic      status
);
    typedef struct packed {
        logic [31:0]                      tick;
        logic [9:0]                       zeros;
        logic [e1_oh_pkg::FAR_END_BLOCK_ERROR_SECONDS-1:0] hist;
        logic                             status;
    } sec_s;

    sec_s q;
    sec_s d;

    always_comb begin
        d = q;
        if (!enable) begin
            d = '0;
        end else begin
            if (zeroEvt && q.zeros != 10'h3FF) begin
                d.zeros = q.zeros + 10'h001;
            end
            if (q.tick == 32'(SECOND_CYCLES_P - 1)) begin
                d.tick = '0;
                d.hist = {q.hist[e1_oh_pkg::FAR_END_BLOCK_ERROR_SECONDS-2:0],
                          d.zeros >= e1_oh_pkg::FAR_END_BLOCK_ERROR_PER_SECOND};
                d.zeros = '0;
            end else begin
                d.tick = q.tick + 32'h1;
            end
            d.status = &d.hist;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign status = q.status;

    cfebe_suspend_a: assert property (@(posedge core_clk) disable iff (!rstn)
        !enable |=> !status)
        else $error("Continuous FAR_END_BLOCK_ERROR status held outside CRC sync");

endmodule // zero_second_monitor
`default_nettype wire

// [rtl/e1_overhead_bit_monitor.sv]
// Purpose: receive-side E1 overhead bit monitor with APB registers
// Assumes: framer strobes are synchronous to core_clk
// Notes: one channel; irqN low while any enabled flag is set
// Operation
// - Mode 0 in CRC sync: compare every 12 Sa6 bits with five codes.
// - Mode 1 in CRC sync: compare 3 consecutive Sa6 codewords with codes.
// - Debounce enable bit switches codeword debouncing on or off.
// - Debounced codeword updates after two equal sub multiframes, else every one.
// - Special code indication is 1 on a match, 0 otherwise.
// - Special code enable gates its indication onto the interrupt pin.
// - A change of any captured Sa4..Sa8 codeword sets its change flag.
// - Five change enables gate their change flags onto the interrupt pin.
// - In CRC sync, A=1 with E=0 for 10 ms sets continuous REMOTE_ALARM_INDICATION status.
// - In CRC sync, 990 zero E bits per second for 5 seconds sets status.
// - In basic sync, 2 zeros among last 3 Sa7 bits sets link status.
// - Sa6 codeword 0010 or 0011 raises the NT CRC error flag.
// - Sa6 codeword 0001 or 0011 raises the NT FAR_END_BLOCK_ERROR flag.
// - In CRC sync a zero E bit raises the FAR_END_BLOCK_ERROR flag; suspended otherwise.
// - Any edge of continuous REMOTE_ALARM_INDICATION status sets its change flag.
// - Any edge of continuous FAR_END_BLOCK_ERROR status sets its change flag.
// - Any edge of link ID status sets its change flag.
// - Overhead flags stay set until software writes 1 to them.
// - Per-flag enables let each overhead flag drive the interrupt pin.
`timescale 1ns/1ns
`default_nettype none
module e1_overhead_bit_monitor #(
    parameter int RAI_CYCLES_P    = e1_oh_pkg::RAI_CYCLES,
    parameter int SECOND_CYCLES_P = e1_oh_pkg::SECOND_CYCLES
) (
    input  wire logic              core_clk,
    input  wire logic              rstn,
    input  wire e1_oh_pkg::frame_s frameIn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    output logic                   irqN
);
    typedef struct packed {
        logic [7:0]  saCtrl;
        logic [4:0]  saFlags;
        logic        special;
        logic [5:0]  ohCtrl;
        logic [5:0]  ohFlags;
        logic        raiCond;
        logic [31:0] raiCnt;
        logic        raiStat;
        logic        cfebePrev;
        logic        linkStat;
        logic [2:0]  sa7Zeros;
        logic [11:0] sa6Bits;
        logic [11:0] sa6Words;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic        irqN;
    } mon_s;

    mon_s q;
    mon_s d;

    e1_oh_pkg::regsel_e sel;
    logic               access;
    logic               wrDone;
    logic [4:0]         saClr;
    logic [5:0]         ohClr;
    logic [5:0]         ohSet;
    logic [3:0]         raw6;
    logic [4:0]         saChanged;
    logic [4:0][3:0]    rawWords;
    logic               cfebeStat;
    logic               febeEvt;

    function automatic e1_oh_pkg::regsel_e decodeAddr(input logic [11:0] a);
        decodeAddr = e1_oh_pkg::SEL_NONE;
        if (a[1:0] == 2'h0 && a[11:10] == 2'h0) begin
            case (a[9:2])
                e1_oh_pkg::IDX_SA_CTRL: decodeAddr = e1_oh_pkg::SEL_SA_CTRL;
                e1_oh_pkg::IDX_SA_IND:  decodeAddr = e1_oh_pkg::SEL_SA_IND;
                e1_oh_pkg::IDX_OH_STAT: decodeAddr = e1_oh_pkg::SEL_OH_STAT;
                e1_oh_pkg::IDX_OH_CTRL: decodeAddr = e1_oh_pkg::SEL_OH_CTRL;
                e1_oh_pkg::IDX_OH_IND:  decodeAddr = e1_oh_pkg::SEL_OH_IND;
                default:                decodeAddr = e1_oh_pkg::SEL_NONE;
            endcase
        end
    endfunction

    // One capture per national bit, Sa4 at index 4 down to Sa8 at index 0
    for (genvar i = 0; i < e1_oh_pkg::NAT_BITS; i++) begin : g_nat
        nat_word_capture u_cap (
            .core_clk   (core_clk),
            .rstn       (rstn),
            .crcMfSync  (frameIn.crcMfSync),
            .bitStrobe  (frameIn.nfasStrobe && frameIn.basicSync),
            .bitIn      (frameIn.saBits[i]),
            .smfEnd     (frameIn.smfEnd),
            .debounceEn (q.saCtrl[e1_oh_pkg::SA_DEB_BIT]),
            .rawWord    (rawWords[i]),
            .word       (),
            .changed    (saChanged[i])
        );
    end

    assign febeEvt = frameIn.eStrobe && frameIn.crcMfSync && !frameIn.eBit;

    zero_second_monitor #(
        .SECOND_CYCLES_P (SECOND_CYCLES_P)
    ) u_cfebe (
        .core_clk (core_clk),
        .rstn     (rstn),
        .enable   (frameIn.crcMfSync),
        .zeroEvt  (febeEvt),
        .status   (cfebeStat)
    );

    always_comb begin
        d      = q;
        sel    = decodeAddr(paddr);
        access = psel && penable;
        wrDone = access && q.pready && pwrite;
        saClr  = '0;
        ohClr  = '0;
        raw6   = rawWords[e1_oh_pkg::SA6_POS];

        // Answer one cycle into the access phase
        d.pready  = access && !q.pready;
        d.pslverr = access && !q.pready && sel == e1_oh_pkg::SEL_NONE;
        d.prdata  = '0;
        if (access && !q.pready && !pwrite) begin
            case (sel)
                e1_oh_pkg::SEL_SA_CTRL: d.prdata[7:0] = q.saCtrl;
                e1_oh_pkg::SEL_SA_IND:  d.prdata[7:0] = {2'h0, q.special, q.saFlags};
                e1_oh_pkg::SEL_OH_STAT: d.prdata[7:0] = {5'h00, q.raiStat, cfebeStat,
                                                         q.linkStat};
                e1_oh_pkg::SEL_OH_CTRL: d.prdata[7:0] = {2'h0, q.ohCtrl};
                e1_oh_pkg::SEL_OH_IND:  d.prdata[7:0] = {2'h0, q.ohFlags};
                default:                d.prdata      = '0;
            endcase
        end

        if (wrDone) begin
            case (sel)
                e1_oh_pkg::SEL_SA_CTRL: d.saCtrl = pwdata[7:0];
                e1_oh_pkg::SEL_SA_IND:  saClr    = pwdata[4:0];
                e1_oh_pkg::SEL_OH_CTRL: d.ohCtrl = pwdata[5:0];
                e1_oh_pkg::SEL_OH_IND:  ohClr    = pwdata[5:0];
                default:                d.ohCtrl = q.ohCtrl;
            endcase
        end

        // Sa6 and Sa7 bit histories from each NFAS frame
        if (frameIn.nfasStrobe && frameIn.basicSync) begin
            d.sa6Bits  = {q.sa6Bits[10:0], frameIn.saBits[e1_oh_pkg::SA6_POS]};
            d.sa7Zeros = {q.sa7Zeros[1:0], !frameIn.saBits[e1_oh_pkg::SA7_POS]};
        end
        if (!frameIn.basicSync) begin
            d.sa7Zeros = '0;
        end
        if (frameIn.smfEnd && frameIn.crcMfSync) begin
            d.sa6Words = {q.sa6Words[7:0], raw6};
        end

        // Special code match, bitwise or per codeword
        if (q.saCtrl[e1_oh_pkg::SA_MODE_BIT]) begin
            d.special = frameIn.crcMfSync && e1_oh_pkg::isSpecial(q.sa6Words);
        end else begin
            d.special = frameIn.crcMfSync && e1_oh_pkg::isSpecial(q.sa6Bits);
        end

        // Link ID: at least two zeros among the last three Sa7 bits
        d.linkStat = frameIn.basicSync &&
                     ((q.sa7Zeros[0] && q.sa7Zeros[1]) ||
                      (q.sa7Zeros[0] && q.sa7Zeros[2]) ||
                      (q.sa7Zeros[1] && q.sa7Zeros[2]));

        // Continuous REMOTE_ALARM_INDICATION with zero E bits, timed on the core clock
        if (!frameIn.crcMfSync) begin
            d.raiCond = 1'b0;
            d.raiCnt  = '0;
        end else begin
            if (frameIn.eStrobe) begin
                d.raiCond = frameIn.aBit && !frameIn.eBit;
            end
            if (frameIn.nfasStrobe && !frameIn.aBit) begin
                d.raiCond = 1'b0;
            end
            if (!d.raiCond) begin
                d.raiCnt = '0;
            end else if (q.raiCnt != 32'(RAI_CYCLES_P)) begin
                d.raiCnt = q.raiCnt + 32'h1;
            end
        end
        d.raiStat = d.raiCond && d.raiCnt == 32'(RAI_CYCLES_P);

        ohSet = '0;
        ohSet[e1_oh_pkg::OH_NT_CRC] = frameIn.smfEnd && frameIn.crcMfSync &&
            (raw6 == e1_oh_pkg::NT_CRC_CODE_A || raw6 == e1_oh_pkg::NT_BOTH_CODE);
        ohSet[e1_oh_pkg::OH_NT_FAR_END_BLOCK_ERROR] = frameIn.smfEnd && frameIn.crcMfSync &&
            (raw6 == e1_oh_pkg::NT_FAR_END_BLOCK_ERROR_CODE_A || raw6 == e1_oh_pkg::NT_BOTH_CODE);
        ohSet[e1_oh_pkg::OH_FAR_END_BLOCK_ERROR] = febeEvt;
        ohSet[e1_oh_pkg::OH_RAI_CHG] = d.raiStat != q.raiStat;
        ohSet[e1_oh_pkg::OH_CFEBE_CHG] = cfebeStat != q.cfebePrev;
        ohSet[e1_oh_pkg::OH_LINK_CHG] = d.linkStat != q.linkStat;
        d.cfebePrev = cfebeStat;

        // Set wins over a clear in the same cycle
        d.saFlags = (q.saFlags & ~saClr) | saChanged;
        d.ohFlags = (q.ohFlags & ~ohClr) | ohSet;

        d.irqN = !((|(q.saFlags & q.saCtrl[4:0])) ||
                   (q.special && q.saCtrl[e1_oh_pkg::SA_SPEC_BIT]) ||
                   (|(q.ohFlags & q.ohCtrl)));
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            q        <= '0;
            q.saCtrl <= e1_oh_pkg::REG_RESET;
            q.irqN   <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign prdata  = q.prdata;
    assign pready  = q.pready;
    assign pslverr = q.pslverr;
    assign irqN    = q.irqN;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    irq_assert_a: assert property ((|(q.ohFlags & q.ohCtrl)) |=> !irqN)
        else $error("Enabled overhead flag did not pull the interrupt low");

    irq_release_a: assert property ((q.ohFlags == '0 && q.saFlags == '0 && !q.special)
        |=> irqN)
        else $error("Interrupt held low with no flag set");

    sa_irq_gate_a: assert property ((q.saFlags & q.saCtrl[4:0]) != '0 |=> !irqN)
        else $error("Enabled codeword change flag did not raise the interrupt");

    special_irq_a: assert property (q.special && q.saCtrl[e1_oh_pkg::SA_SPEC_BIT]
        |=> !irqN)
        else $error("Enabled special code did not raise the interrupt");

    flag_sticky_a: assert property (q.ohFlags[e1_oh_pkg::OH_FAR_END_BLOCK_ERROR] &&
        !(wrDone && sel == e1_oh_pkg::SEL_OH_IND) |=> q.ohFlags[e1_oh_pkg::OH_FAR_END_BLOCK_ERROR])
        else $error("FAR_END_BLOCK_ERROR flag dropped without a write");

    w1c_clear_a: assert property (wrDone && sel == e1_oh_pkg::SEL_OH_IND &&
        pwdata[e1_oh_pkg::OH_NT_CRC] && !ohSet[e1_oh_pkg::OH_NT_CRC]
        |=> !q.ohFlags[e1_oh_pkg::OH_NT_CRC])
        else $error("Write of one did not clear the NT CRC flag");

    far_end_block_error_set_a: assert property (frameIn.eStrobe && frameIn.crcMfSync && !frameIn.eBit
        |=> q.ohFlags[e1_oh_pkg::OH_FAR_END_BLOCK_ERROR])
        else $error("Zero E bit did not raise the FAR_END_BLOCK_ERROR flag");

    far_end_block_error_suspend_a: assert property (!frameIn.crcMfSync && !q.ohFlags[e1_oh_pkg::OH_FAR_END_BLOCK_ERROR]
        |=> !q.ohFlags[e1_oh_pkg::OH_FAR_END_BLOCK_ERROR])
        else $error("FAR_END_BLOCK_ERROR flag rose outside CRC sync");

    nt_crc_a: assert property (frameIn.smfEnd && frameIn.crcMfSync && raw6 == 4'h2
        |=> q.ohFlags[e1_oh_pkg::OH_NT_CRC] && !q.ohFlags[e1_oh_pkg::OH_NT_FAR_END_BLOCK_ERROR] ||
            $past(q.ohFlags[e1_oh_pkg::OH_NT_FAR_END_BLOCK_ERROR]))
        else $error("Codeword 0010 handled wrongly");

    rai_change_a: assert property ($changed(q.raiStat) |-> q.ohFlags[e1_oh_pkg::OH_RAI_CHG])
        else $error("REMOTE_ALARM_INDICATION status edge without change flag");

    cfebe_change_a: assert property ($changed(cfebeStat) |=> q.ohFlags[e1_oh_pkg::OH_CFEBE_CHG])
        else $error("Continuous FAR_END_BLOCK_ERROR edge without change flag");

    link_change_a: assert property ($changed(q.linkStat) |-> q.ohFlags[e1_oh_pkg::OH_LINK_CHG])
        else $error("Link ID edge without change flag");

    rai_time_a: assert property ($rose(q.raiStat) |-> q.raiCnt == 32'(RAI_CYCLES_P))
        else $error("REMOTE_ALARM_INDICATION status rose before its time");

    special_zero_a: assert property (!frameIn.crcMfSync |=> !q.special)
        else $error("Special code indication outside CRC sync");

    link_sync_a: assert property (!frameIn.basicSync |=> !q.linkStat)
        else $error("Link status outside basic sync");

    sa_flag_a: assert property (saChanged[e1_oh_pkg::SA6_POS] |=> q.saFlags[e1_oh_pkg::SA6_POS])
        else $error("Sa6 codeword change did not set its flag");

    bit_match_a: assert property (!q.saCtrl[e1_oh_pkg::SA_MODE_BIT] &&
        frameIn.crcMfSync && e1_oh_pkg::isSpecial(q.sa6Bits) |=> q.special)
        else $error("Matching Sa6 bits did not raise the special indication");

    word_match_a: assert property (q.saCtrl[e1_oh_pkg::SA_MODE_BIT] &&
        frameIn.crcMfSync && e1_oh_pkg::isSpecial(q.sa6Words) |=> q.special)
        else $error("Matching codewords did not raise the special indication");

    special_off_a: assert property (!q.saCtrl[e1_oh_pkg::SA_MODE_BIT] &&
        !e1_oh_pkg::isSpecial(q.sa6Bits) |=> !q.special)
        else $error("Special code indication without a match");

    sa_ctrl_wr_a: assert property (wrDone && sel == e1_oh_pkg::SEL_SA_CTRL
        |=> q.saCtrl == $past(pwdata[7:0]))
        else $error("Codeword control write did not land");

    sa_sticky_a: assert property (q.saFlags[e1_oh_pkg::SA6_POS] &&
        !(wrDone && sel == e1_oh_pkg::SEL_SA_IND) |=> q.saFlags[e1_oh_pkg::SA6_POS])
        else $error("Sa6 change flag dropped without a write");

    nt_far_end_block_error_a: assert property (frameIn.smfEnd && frameIn.crcMfSync &&
        raw6 == e1_oh_pkg::NT_FAR_END_BLOCK_ERROR_CODE_A |=> q.ohFlags[e1_oh_pkg::OH_NT_FAR_END_BLOCK_ERROR])
        else $error("Codeword 0001 did not raise the NT FAR_END_BLOCK_ERROR flag");

    nt_both_a: assert property (frameIn.smfEnd && frameIn.crcMfSync &&
        raw6 == e1_oh_pkg::NT_BOTH_CODE |=> q.ohFlags[e1_oh_pkg::OH_NT_CRC] &&
        q.ohFlags[e1_oh_pkg::OH_NT_FAR_END_BLOCK_ERROR])
        else $error("Codeword 0011 did not raise both NT flags");

    link_set_a: assert property (frameIn.basicSync &&
        q.sa7Zeros[1:0] == 2'b11 |=> q.linkStat)
        else $error("Two zero Sa7 bits did not raise link status");

    link_sticky_a: assert property (q.ohFlags[e1_oh_pkg::OH_LINK_CHG] &&
        !(wrDone && sel == e1_oh_pkg::SEL_OH_IND) |=> q.ohFlags[e1_oh_pkg::OH_LINK_CHG])
        else $error("Link change flag dropped without a write");

    rai_sync_a: assert property (!frameIn.crcMfSync |=> !q.raiStat)
        else $error("REMOTE_ALARM_INDICATION status held outside CRC sync");

    rai_break_a: assert property (frameIn.nfasStrobe && !frameIn.aBit |=> !q.raiStat)
        else $error("REMOTE_ALARM_INDICATION status held after A bit returned to zero");

    apb_wait_c: cover property (psel && !penable ##1 access && !pready ##1 pready);
    far_end_block_error_irq_c: cover property (febeEvt ##[1:3] !irqN);
    special_c: cover property ($rose(q.special));
    rai_c: cover property ($rose(q.raiStat));
    link_c: cover property ($rose(q.linkStat));

endmodule // e1_overhead_bit_monitor
`default_nettype wire

// [verif/e1_overhead_bit_monitor_test.sv]
// Purpose: self-checking bench for the E1 overhead bit monitor
// Assumes: APB answers after one wait state; short REMOTE_ALARM_INDICATION and second counts
// Notes: transfers note expected data in a queue, a monitor compares on pready
`timescale 1ns/1ns
`default_nettype none
module e1_overhead_bit_monitor_test;
    localparam int          REMOTE_ALARM_INDICATION   = 20;
    localparam int          SEC   = 1000;
    localparam logic [11:0] A_SC  = {2'h0, e1_oh_pkg::IDX_SA_CTRL, 2'h0};
    localparam logic [11:0] A_SI  = {2'h0, e1_oh_pkg::IDX_SA_IND, 2'h0};
    localparam logic [11:0] A_ST  = {2'h0, e1_oh_pkg::IDX_OH_STAT, 2'h0};
    localparam logic [11:0] A_OC  = {2'h0, e1_oh_pkg::IDX_OH_CTRL, 2'h0};
    localparam logic [11:0] A_OI  = {2'h0, e1_oh_pkg::IDX_OH_IND, 2'h0};
    localparam logic [11:0] A_BAD = 12'h178;

    logic              core_clk;
    logic              rstn;
    e1_oh_pkg::frame_s fr;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [11:0]       paddr;
    logic [31:0]       pwdata;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic              irqN;
    logic [33:0]       expQ[$];
    logic [33:0]       expNow;
    logic [31:0]       seed;
    logic [31:0]       r;
    int                errorCnt;
    int                checkCount;

    e1_overhead_bit_monitor #(.RAI_CYCLES_P(REMOTE_ALARM_INDICATION), .SECOND_CYCLES_P(SEC)) DUT (
        .core_clk(core_clk), .rstn(rstn), .frameIn(fr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irqN(irqN));

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checkCount++;
        if (seen !== exp) begin
            errorCnt++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic finalReport();
        $display("Checks %0d, mismatches %0d", checkCount, errorCnt);
        if (errorCnt == 0 && checkCount > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Bit 33 marks a read, bit 32 the expected error response
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [31:0] exp, input logic err);
        @(posedge core_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        expQ.push_back({~w, err, exp});
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, exp, 1'b0);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 32'h0, 1'b0);
    endtask

    task automatic irq(input logic e);
        repeat (3) @(posedge core_clk);
        chk({31'h0, irqN}, {31'h0, e});
    endtask

    task automatic nfas(input logic a, input logic [4:0] s);
        @(posedge core_clk);
        fr.nfasStrobe <= 1'b1;
        fr.aBit       <= a;
        fr.saBits     <= s;
        @(posedge core_clk);
        fr.nfasStrobe <= 1'b0;
    endtask

    task automatic ezero(input int n);
        @(posedge core_clk);
        fr.eStrobe <= 1'b1;
        fr.eBit    <= 1'b0;
        repeat (n) @(posedge core_clk);
        fr.eStrobe <= 1'b0;
        fr.eBit    <= 1'b1;
    endtask

    // One sub multiframe, first bit is the codeword MSB; o feeds Sa4,5,7,8
    task automatic smf(input logic [3:0] s6, input logic [3:0] o);
        for (int i = 3; i >= 0; i--) begin
            nfas(1'b0, {o[i], o[i], s6[i], o[i], o[i]});
        end
        @(posedge core_clk);
        fr.smfEnd <= 1'b1;
        @(posedge core_clk);
        fr.smfEnd <= 1'b0;
        repeat (3) @(posedge core_clk);
    endtask

    task automatic done(input string s);
        $display("Test %s finished", s);
    endtask

    always @(posedge core_clk) begin
        if (pready === 1'b1) begin
            if (expQ.size() == 0) begin
                chk(32'h1, 32'h0);
            end else begin
                expNow = expQ.pop_front();
                chk({31'h0, pslverr}, {31'h0, expNow[32]});
                if (expNow[33]) chk(prdata, expNow[31:0]);
            end
        end
    end

    initial begin
        repeat (30000) @(posedge core_clk);
        errorCnt++;
        finalReport();
    end

    initial begin
        fr = '0;
        fr.basicSync = 1'b1;
        fr.eBit = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        seed = 32'h45;
        errorCnt = 0;
        checkCount = 0;
        rstn = 1'b0;
        repeat (2) @(posedge core_clk);
        rstn <= 1'b1;
        rd(A_SC, 32'h0);
        rd(A_SI, 32'h0);
        rd(A_ST, 32'h0);
        rd(A_OC, 32'h0);
        rd(A_OI, 32'h0);
        apb(1'b0, A_BAD, 32'h0, 32'h0, 1'b1);
        irq(1'b1);
        r = xs();
        wr(A_SC, r);
        rd(A_SC, {24'h0, r[7:0]});
        wr(A_OC, r);
        rd(A_OC, {26'h0, r[5:0]});
        wr(A_SC, 32'h0);
        wr(A_OC, 32'h08);
        done("registers");
        ezero(1);
        rd(A_OI, 32'h0);
        fr.crcMfSync <= 1'b1;
        ezero(1);
        irq(1'b0);
        rd(A_OI, 32'h08);
        wr(A_OI, 32'h08);
        irq(1'b1);
        rd(A_OI, 32'h0);
        done("far_end_block_error");
        ezero(7 * SEC);
        rd(A_ST, 32'h02);
        repeat (3 * SEC) @(posedge core_clk);
        rd(A_ST, 32'h0);
        rd(A_OI, 32'h0A);
        wr(A_OI, 32'h3F);
        done("continuous far_end_block_error");
        wr(A_SC, 32'h1F);
        repeat (3) smf(4'h8, 4'hF);
        rd(A_SI, 32'h3F);
        irq(1'b0);
        wr(A_SI, 32'h1F);
        irq(1'b1);
        rd(A_SI, 32'h20);
        wr(A_SC, 32'h20);
        irq(1'b0);
        wr(A_SC, 32'h0);
        smf(4'h1, 4'hF);
        rd(A_SI, 32'h04);
        rd(A_OI, 32'h10);
        smf(4'h3, 4'hF);
        rd(A_OI, 32'h30);
        wr(A_OC, 32'h20);
        irq(1'b0);
        wr(A_OC, 32'h0);
        irq(1'b1);
        smf(4'h2, 4'h0);
        rd(A_ST, 32'h01);
        smf(4'h2, 4'hF);
        rd(A_ST, 32'h0);
        rd(A_OI, 32'h31);
        wr(A_OI, 32'h3F);
        wr(A_SI, 32'h1F);
        wr(A_SC, 32'hC0);
        smf(4'hA, 4'hF);
        rd(A_SI, 32'h0);
        smf(4'hA, 4'hF);
        rd(A_SI, 32'h04);
        smf(4'hA, 4'hF);
        rd(A_SI, 32'h24);
        nfas(1'b0, 5'h1B);
        rd(A_SI, 32'h24);
        done("national bits");
        nfas(1'b1, 5'h1F);
        ezero(1);
        repeat (2 * REMOTE_ALARM_INDICATION) @(posedge core_clk);
        rd(A_ST, 32'h04);
        nfas(1'b0, 5'h1F);
        rd(A_ST, 32'h0);
        rd(A_OI, 32'h0C);
        done("remote alarm");
        repeat (5) @(posedge core_clk);
        finalReport();
    end
endmodule // e1_overhead_bit_monitor_test
`default_nettype wire
